// ==== rtl/bsc_hall_decode.sv ====
// hall level recovery and six-step commutation decode
`timescale 1ns/1ps
module bsc_hall_decode (
    input wire bsc_pkg::bsc_hall_in_s hall_in,
    input wire logic dir_rev,
    output logic [2:0] hall_code,
    output bsc_pkg::bsc_drive_s sel
);

    function automatic bsc_pkg::bsc_drive_s step_fwd(input logic [2:0] code);
        bsc_pkg::bsc_drive_s d;
        d = '0;
        unique case (code)
            3'h1: d = '{hi: 3'h1, lo: 3'h2};
            3'h3: d = '{hi: 3'h1, lo: 3'h4};
            3'h2: d = '{hi: 3'h2, lo: 3'h4};
            3'h6: d = '{hi: 3'h2, lo: 3'h1};
            3'h4: d = '{hi: 3'h4, lo: 3'h1};
            3'h5: d = '{hi: 3'h4, lo: 3'h2};
            default: d = '0;
        endcase
        return d;
    endfunction

    bsc_pkg::bsc_drive_s fwd;

    always_comb begin
        // a phase reads high only while its positive input is above the negative [RULE8]
        hall_code[0] = hall_in.hall_a_pos > hall_in.hall_a_neg;
        hall_code[1] = hall_in.hall_b_pos > hall_in.hall_b_neg;
        hall_code[2] = hall_in.hall_c_pos > hall_in.hall_c_neg;
        fwd = step_fwd(hall_code); // [RULE16]
        // reverse swaps upper and lower, turning the torque round [RULE7] [RULE16]
        if (dir_rev) begin
            sel.hi = fwd.lo;
            sel.lo = fwd.hi;
        end else begin
            sel = fwd;
        end
    end

endmodule // bsc_hall_decode

// ==== rtl/bsc_pkg.sv ====
// constants, types and register map of the brushless speed control logic
package bsc_pkg;

    // system clock
    localparam int unsigned CLK_HZ = 200000000;

    // reference divider: one servo period is 8192 reference edges
    localparam int unsigned REF_DIVIDE = 8192;
    localparam logic [12:0] REF_DIV_MAX = 13'h1FFF;
    localparam logic [12:0] REF_DIV_HALF = 13'h1000;

    // discriminator works over two speed pulse periods
    localparam logic [15:0] PAIR_TARGET = 16'h4000;
    // lock window is one sixteenth of the target, i.e. 6.25 percent
    localparam logic [15:0] LOCK_TOL = 16'h0400;
    localparam logic [15:0] MEAS_SAT = 16'hFFFF;

    // restraint protection interval
    localparam int unsigned RESTRAINT_MS = 3300;
    localparam int unsigned RESTRAINT_CYC = RESTRAINT_MS * (CLK_HZ / 1000);

    // pwm carrier
    localparam int unsigned PWM_FREQ_HZ = 20000;
    localparam int unsigned PWM_STEPS = 256;
    localparam logic [5:0] PWM_PRE_MAX = 6'(CLK_HZ / (PWM_FREQ_HZ * PWM_STEPS) - 1);
    localparam logic [7:0] PWM_CNT_MAX = 8'hFF;

    // register byte offsets
    localparam logic [7:0] ADDR_CTRL = 8'h00;
    localparam logic [7:0] ADDR_STATUS = 8'h04;
    localparam logic [7:0] ADDR_INT_STAT = 8'h08;
    localparam logic [7:0] ADDR_INT_MASK = 8'h0C;
    localparam logic [7:0] ADDR_MEAS = 8'h10;

    // reset values
    localparam logic [7:0] DUTY_MAX_RST = 8'hC0;
    localparam logic [3:0] INT_MASK_RST = 4'h0;

    // event bits of the interrupt status and mask registers
    localparam int NEV = 4;
    localparam int EV_LOCK = 0;
    localparam int EV_UNLOCK = 1;
    localparam int EV_TRIP = 2;
    localparam int EV_CLIM = 3;

    typedef enum logic [2:0] {
        M_SAVE = 3'b001,
        M_RUN = 3'b010,
        M_TRIP = 3'b100
    } bsc_mode_e;

    // digitised hall amplitudes, one pair per phase
    typedef struct packed {
        logic [7:0] hall_a_pos;
        logic [7:0] hall_a_neg;
        logic [7:0] hall_b_pos;
        logic [7:0] hall_b_neg;
        logic [7:0] hall_c_pos;
        logic [7:0] hall_c_neg;
    } bsc_hall_in_s;

    // one bit per phase, bit 0 is phase a
    typedef struct packed {
        logic [2:0] hi;
        logic [2:0] lo;
    } bsc_drive_s;

    typedef struct packed {
        bsc_mode_e mode;
        logic power_save;
        logic ref_q;
        logic sp_q;
        logic [12:0] ref_div;
        logic [15:0] meas_cnt;
        logic pair;
        logic res;
        logic [15:0] meas_last;
        logic disc;
        logic phase;
        logic lock_n;
        logic [7:0] duty;
        logic [7:0] duty_max;
        logic [5:0] pre;
        logic [7:0] pwm_cnt;
        logic climit;
        logic cl_q;
        logic [31:0] rcnt;
        bsc_drive_s drive;
        logic [NEV-1:0] int_stat;
        logic [NEV-1:0] int_mask;
        logic irq;
        logic [31:0] prdata;
        logic pready;
        logic pslverr;
    } bsc_state_s;

endpackage

// ==== rtl/bsc_top.sv ====
// speed loop, protection, pwm drive and apb registers of the motor driver
// Notes on behaviour
// RULE1 - discriminator issues one speed deviation result every two speed pulses
// RULE2 - phase error output refreshed once per speed pulse against divided reference
// RULE3 - target speed pulse rate is the reference rate divided by 8192
// RULE4 - discriminator output high to accelerate, low to decelerate
// RULE5 - lock flag low while speed within 6.25 percent of target, else high
// RULE6 - run/stop low runs, high stops; an open input means stop
// RULE7 - direction low is forward, high is reverse; open input means reverse
// RULE8 - each hall pair reads high when positive input exceeds negative
// RULE9 - stop enters power save, speed logic unbiased, regulator stays on
// RULE10 - at peak current the on duty is cut so the current falls
// RULE11 - pwm only on the active lower transistor, upper held on
// RULE12 - drive power set only by on duty, outputs fully on or off
// RULE13 - control logic held reset while the reset node is still charging
// RULE14 - lock lost for the protection interval while running latches lower side off
// RULE15 - latched restraint cleared only by stop or power cycle in stop
// RULE16 - hall levels decode to six-step pattern, reversed for reverse direction
// RULE17 - all outputs off during stop or reset
`timescale 1ns/1ps
module bsc_top #(
    parameter int unsigned RESTRAINT_CYCLES = bsc_pkg::RESTRAINT_CYC
) (
    input wire logic clk,
    input wire logic rstn,
    input wire logic [7:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic ref_osc_in,
    input wire logic speed_pulse,
    input wire logic por_node,
    input wire logic stop_req,
    input wire logic dir_rev,
    input wire bsc_pkg::bsc_hall_in_s hall_in,
    input wire logic cur_limit,
    input wire logic restraint_en,
    output bsc_pkg::bsc_drive_s drive,
    output logic disc_out,
    output logic phase_error_out,
    output logic speed_lock_flag_n,
    output logic power_save,
    output logic irq
);

    function automatic logic lock_ok(input logic [15:0] c);
        return (c >= bsc_pkg::PAIR_TARGET - bsc_pkg::LOCK_TOL)
            && (c <= bsc_pkg::PAIR_TARGET + bsc_pkg::LOCK_TOL);
    endfunction

    function automatic logic reg_mapped(input logic [7:0] a);
        return a == bsc_pkg::ADDR_CTRL || a == bsc_pkg::ADDR_STATUS
            || a == bsc_pkg::ADDR_INT_STAT || a == bsc_pkg::ADDR_INT_MASK
            || a == bsc_pkg::ADDR_MEAS;
    endfunction

    bsc_pkg::bsc_state_s s;
    bsc_pkg::bsc_state_s n;
    bsc_pkg::bsc_drive_s sel;
    logic [2:0] hall_code;
    logic run;
    logic ref_edge;
    logic sp_edge;
    logic pwm_on;
    logic wr;
    logic setup;
    logic [bsc_pkg::NEV-1:0] ev;
    logic [bsc_pkg::NEV-1:0] clr;

    bsc_hall_decode u_hall (
        .hall_in(hall_in),
        .dir_rev(dir_rev),
        .hall_code(hall_code),
        .sel(sel)
    );

    always_comb begin
        n = s;
        ev = '0;
        clr = '0;
        // stop_req high (pad pulled high when open) stops; reset node low holds the speed and drive logic, not the registers
        run = por_node && !stop_req; // [RULE6] [RULE13]
        ref_edge = ref_osc_in && !s.ref_q;
        sp_edge = speed_pulse && !s.sp_q;
        n.ref_q = ref_osc_in;
        n.sp_q = speed_pulse;
        n.res = 1'b0;
        n.power_save = !run; // [RULE9]

        unique case (s.mode)
            bsc_pkg::M_SAVE: begin
                if (run) begin
                    n.mode = bsc_pkg::M_RUN;
                end
            end
            bsc_pkg::M_RUN: begin
                if (!run) begin
                    n.mode = bsc_pkg::M_SAVE;
                end else if (restraint_en && s.lock_n && s.rcnt == RESTRAINT_CYCLES - 1) begin
                    n.mode = bsc_pkg::M_TRIP; // [RULE14]
                    ev[bsc_pkg::EV_TRIP] = 1'b1;
                end
            end
            bsc_pkg::M_TRIP: begin
                if (!run) begin
                    n.mode = bsc_pkg::M_SAVE; // [RULE15]
                end
            end
            default: n.mode = bsc_pkg::M_SAVE;
        endcase

        // protection interval counts only while running and out of lock
        if (!run || !s.lock_n || !restraint_en || s.mode != bsc_pkg::M_RUN) begin
            n.rcnt = 32'h0;
        end else begin
            n.rcnt = s.rcnt + 32'h1; // [RULE14]
        end

        if (!run) begin
            // unbiased speed logic: all but meas_last restarts from a clean state [RULE9] [RULE13]
            n.ref_div = 13'h0;
            n.meas_cnt = 16'h0;
            n.pair = 1'b0;
            n.disc = 1'b0;
            n.phase = 1'b0;
            n.lock_n = 1'b1;
            n.duty = 8'h0;
            n.pre = 6'h0;
            n.pwm_cnt = 8'h0;
            n.climit = 1'b0;
        end else begin
            if (ref_edge) begin
                n.ref_div = s.ref_div + 13'h1; // wraps every 8192 edges [RULE3]
                if (s.meas_cnt != bsc_pkg::MEAS_SAT) begin
                    n.meas_cnt = s.meas_cnt + 16'h1;
                end
            end
            if (sp_edge) begin
                // pulse ahead of the divided reference reads low, behind reads high [RULE2]
                n.phase = s.ref_div < bsc_pkg::REF_DIV_HALF;
                if (s.pair) begin
                    // second pulse of the pair closes one measurement [RULE1]
                    n.res = 1'b1;
                    n.pair = 1'b0;
                    n.meas_cnt = 16'h0;
                    n.meas_last = s.meas_cnt;
                    n.disc = s.meas_cnt > bsc_pkg::PAIR_TARGET; // slow means accelerate [RULE4]
                    n.lock_n = !lock_ok(s.meas_cnt); // [RULE5]
                    if (n.lock_n != s.lock_n) begin
                        ev[bsc_pkg::EV_LOCK] = !n.lock_n;
                        ev[bsc_pkg::EV_UNLOCK] = n.lock_n;
                    end
                    // speed is steered through the on duty alone [RULE12]
                    if (n.disc && s.duty < s.duty_max) begin
                        n.duty = s.duty + 8'h1;
                    end else if (!n.disc && s.duty != 8'h0) begin
                        n.duty = s.duty - 8'h1;
                    end
                end else begin
                    n.pair = 1'b1;
                end
            end
            if (n.duty > s.duty_max) begin
                n.duty = s.duty_max;
            end
            if (s.pre == bsc_pkg::PWM_PRE_MAX) begin
                n.pre = 6'h0;
                n.pwm_cnt = s.pwm_cnt + 8'h1;
                if (s.pwm_cnt == bsc_pkg::PWM_CNT_MAX) begin
                    n.climit = 1'b0;
                end
            end else begin
                n.pre = s.pre + 6'h1;
            end
            // the limit ends the on time for the rest of the carrier period [RULE10]
            if (cur_limit) begin
                n.climit = 1'b1;
            end
        end
        n.cl_q = cur_limit && run;
        if (cur_limit && run && !s.cl_q) begin
            ev[bsc_pkg::EV_CLIM] = 1'b1;
        end

        pwm_on = (s.pwm_cnt < s.duty) && !s.climit; // [RULE10] [RULE12]
        n.drive = '0; // [RULE17]
        if (run && s.mode != bsc_pkg::M_SAVE) begin
            // upper stays on through the step, only the lower one chops [RULE11]
            n.drive.hi = sel.hi;
            if (s.mode == bsc_pkg::M_RUN && pwm_on) begin
                n.drive.lo = sel.lo;
            end
        end

        setup = psel && !penable;
        wr = psel && penable && pwrite && s.pready;
        if (wr && paddr == bsc_pkg::ADDR_CTRL) begin
            n.duty_max = pwdata[7:0];
        end
        if (wr && paddr == bsc_pkg::ADDR_INT_MASK) begin
            n.int_mask = pwdata[bsc_pkg::NEV-1:0];
        end
        if (wr && paddr == bsc_pkg::ADDR_INT_STAT) begin
            clr = pwdata[bsc_pkg::NEV-1:0];
        end
        // a new event outranks a clear in the same cycle
        n.int_stat = (s.int_stat & ~clr) | ev;
        n.irq = |(n.int_stat & n.int_mask);

        n.pready = setup;
        n.pslverr = setup && !reg_mapped(paddr);
        n.prdata = 32'h0;
        if (setup && !pwrite) begin
            unique case (paddr)
                bsc_pkg::ADDR_CTRL: n.prdata = {16'h0, s.duty, s.duty_max};
                bsc_pkg::ADDR_STATUS: n.prdata = {22'h0, s.power_save, hall_code,
                    s.mode, s.lock_n, s.phase, s.disc};
                bsc_pkg::ADDR_INT_STAT: n.prdata = {28'h0, s.int_stat};
                bsc_pkg::ADDR_INT_MASK: n.prdata = {28'h0, s.int_mask};
                bsc_pkg::ADDR_MEAS: n.prdata = {16'h0, s.meas_last};
                default: n.prdata = 32'h0;
            endcase
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            s <= '0;
            s.mode <= bsc_pkg::M_SAVE;
            s.power_save <= 1'b1;
            s.lock_n <= 1'b1;
            s.duty_max <= bsc_pkg::DUTY_MAX_RST;
            s.int_mask <= bsc_pkg::INT_MASK_RST;
        end else begin
            s <= n;
        end
    end

    assign prdata = s.prdata;
    assign pready = s.pready;
    assign pslverr = s.pslverr;
    assign drive = s.drive;
    assign disc_out = s.disc;
    assign phase_error_out = s.phase;
    assign speed_lock_flag_n = s.lock_n;
    assign power_save = s.power_save;
    assign irq = s.irq;

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rstn);

    sequence first_pulse_s;
        run && sp_edge && !s.pair;
    endsequence

    sequence second_pulse_s;
        run && sp_edge && s.pair;
    endsequence

    disc_pair_open_a: assert property (first_pulse_s |=> s.pair && !s.res) // [RULE1]
        else $error("first pulse of a pair gave a result");

    disc_result_a: assert property ( // [RULE1]
        second_pulse_s |=> s.res && !s.pair && s.meas_last == $past(s.meas_cnt))
        else $error("second pulse did not close the measurement");

    phase_sample_a: assert property ( // [RULE2]
        (run && sp_edge) |=> s.phase == ($past(s.ref_div) < bsc_pkg::REF_DIV_HALF))
        else $error("phase output not taken from divider phase");

    ref_wrap_a: assert property ( // [RULE3]
        (run && ref_edge && s.ref_div == bsc_pkg::REF_DIV_MAX) |=> s.ref_div == 13'h0)
        else $error("reference divider did not wrap at 8192");

    disc_sense_a: assert property ( // [RULE4]
        s.res |-> disc_out == (s.meas_last > bsc_pkg::PAIR_TARGET))
        else $error("discriminator sense wrong");

    lock_window_a: assert property ( // [RULE5]
        s.res |-> speed_lock_flag_n == !lock_ok(s.meas_last))
        else $error("lock flag disagrees with window");

    limit_cut_a: assert property ((run && cur_limit) |-> ##2 (drive.lo == 3'h0)) // [RULE10]
        else $error("lower side still on after current limit");

    upper_held_a: assert property (|drive.lo |-> |drive.hi) // [RULE11]
        else $error("lower side conducts without an upper side");

    trip_latch_a: assert property ( // [RULE14]
        (s.mode == bsc_pkg::M_TRIP && run) |=> s.mode == bsc_pkg::M_TRIP && drive.lo == 3'h0)
        else $error("restraint latch lost or lower side on");

    trip_clear_a: assert property (!run |=> s.mode == bsc_pkg::M_SAVE) // [RULE15]
        else $error("stop did not clear the restraint state");

    stop_off_a: assert property ( // [RULE17]
        !run |=> drive.hi == 3'h0 && drive.lo == 3'h0 && power_save)
        else $error("outputs on or no power save in stop");

    por_hold_a: assert property ( // [RULE13]
        !por_node |=> s.meas_cnt == 16'h0 && !s.pair && !s.res)
        else $error("logic ran while reset node low");

    ref_step_a: assert property ( // [RULE3]
        (run && ref_edge) |=> s.ref_div == $past(s.ref_div) + 13'h1)
        else $error("reference divider skipped a reference edge");

    meas_hold_a: assert property (!s.res |-> $stable(s.meas_last)) // [RULE1]
        else $error("measurement changed without a pair result");

    phase_hold_a: assert property ($past(run) && !$past(sp_edge) |-> $stable(s.phase)) // [RULE2]
        else $error("phase output moved between speed pulses");

    disc_hold_a: assert property ($past(run) && !s.res |-> $stable(disc_out)) // [RULE4]
        else $error("discriminator output moved without a result");

    lock_hold_a: assert property ($past(run) && !s.res |-> $stable(s.lock_n)) // [RULE5]
        else $error("lock flag moved without a result");

    save_clean_a: assert property (!run |=> power_save && s.duty == 8'h0 && !s.pair) // [RULE9]
        else $error("speed logic kept state in power save");

    climit_gate_a: assert property (s.climit |=> drive.lo == 3'h0) // [RULE10]
        else $error("lower side on during a current limit cut");

    duty_ceiling_a: assert property (run |=> s.duty <= $past(s.duty_max)) // [RULE12]
        else $error("on duty above its ceiling");

    lower_duty_a: assert property (|drive.lo |-> $past(s.pwm_cnt < s.duty)) // [RULE12]
        else $error("lower side on outside the duty window");

    // entry into the latched state, one edge after the last running cycle
    sequence trip_entry_s;
        s.mode == bsc_pkg::M_TRIP && $past(s.mode) == bsc_pkg::M_RUN;
    endsequence

    trip_interval_a: assert property ( // [RULE14]
        trip_entry_s |-> $past(s.rcnt) == RESTRAINT_CYCLES - 1 && $past(s.lock_n))
        else $error("restraint tripped before its interval ran out");

endmodule // bsc_top

// ==== tb/bsc_motor_model.sv ====
// motor model: hall pair amplitudes and speed pickup pulses
`timescale 1ns/1ps
module bsc_motor_model (
    input wire logic clk,
    output logic speed_pulse,
    output bsc_pkg::bsc_hall_in_s hall_in
);
    logic [2:0] code_r;
    initial begin
        speed_pulse = 1'b0;
        code_r = 3'h1;
    end
    // the high side of a pair leads by one step only, the narrowest margin
    function automatic logic [15:0] amp(input logic hi);
        return hi ? 16'h8180 : 16'h8081;
    endfunction
    assign hall_in = {amp(code_r[0]), amp(code_r[1]), amp(code_r[2])};
    task automatic set_hall(input logic [2:0] code);
        code_r <= code;
    endtask
    task automatic pulse();
        speed_pulse <= 1'b1;
        repeat (4) @(posedge clk);
        speed_pulse <= 1'b0;
    endtask
endmodule // bsc_motor_model

// ==== tb/tb_top.sv ====
// self-checking bench of the speed control logic
`timescale 1ns/1ps
module tb_top;
    logic clk, rstn, psel, penable, pwrite, ref_osc_in, por_node, stop_req, dir_rev;
    logic cur_limit, restraint_en, pready, pslverr, speed_pulse, disc_out, phase_error_out;
    logic speed_lock_flag_n, power_save, irq;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata;
    bsc_pkg::bsc_hall_in_s hall_in;
    bsc_pkg::bsc_drive_s drive;
    int n_fail = 0;
    int n_compared = 0;
    int cyc = 0;
    localparam logic [2:0] CODES [6] = '{3'h1, 3'h3, 3'h2, 3'h6, 3'h4, 3'h5};
    localparam logic [2:0] UPPER [6] = '{3'h1, 3'h1, 3'h2, 3'h2, 3'h4, 3'h4};
    localparam logic [2:0] LOWER [6] = '{3'h2, 3'h4, 3'h4, 3'h1, 3'h1, 3'h2};

    bsc_top #(.RESTRAINT_CYCLES(2000)) i_bsc_top (.clk(clk), .rstn(rstn), .paddr(paddr),
        .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .ref_osc_in(ref_osc_in),
        .speed_pulse(speed_pulse), .por_node(por_node), .stop_req(stop_req),
        .dir_rev(dir_rev), .hall_in(hall_in), .cur_limit(cur_limit),
        .restraint_en(restraint_en), .drive(drive), .disc_out(disc_out),
        .phase_error_out(phase_error_out), .speed_lock_flag_n(speed_lock_flag_n),
        .power_save(power_save), .irq(irq));
    bsc_motor_model i_bsc_motor_model (.clk(clk), .speed_pulse(speed_pulse),
        .hall_in(hall_in));

    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end
    // reference toggles every clock, so one rising edge every two clocks
    always @(posedge clk) begin
        cyc <= cyc + 1;
        ref_osc_in <= ~ref_osc_in;
    end

    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
                       output logic [31:0] q, output logic err);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        // outputs read right after an edge still hold their pre-edge values
        @(posedge clk);
        while (pready !== 1'b1) begin
            @(posedge clk);
        end
        q = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clk);
    endtask
    task automatic rd(input logic [7:0] a, output logic [31:0] q);
        logic e;
        apb(1'b0, a, 32'h0, q, e);
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] q;
        logic e;
        apb(1'b1, a, d, q, e);
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            n_fail++;
            $display("unexpected at %0t: got %0h expected %0h", $time, got, exp);
        end
    endtask
    task automatic chk_rng(input logic [31:0] got, input logic [31:0] lo, input logic [31:0] hi);
        n_compared++;
        if (!(got >= lo && got <= hi)) begin
            n_fail++;
            $display("unexpected at %0t: got %0h expected %0h..%0h", $time, got, lo, hi);
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
    endtask
    task automatic fire_at(input int t);
        while (cyc < t) @(posedge clk);
        i_bsc_motor_model.pulse();
    endtask
    // counts low side on-cycles and any drive other than the expected pattern
    task automatic watch(input int n, output int seen, output int bad);
        seen = 0;
        bad = 0;
        repeat (n) begin
            @(negedge clk);
            if (drive.lo !== 3'h0) seen++;
            if (drive.hi !== 3'h1 || (drive.lo !== 3'h0 && drive.lo !== 3'h2)) bad++;
        end
        @(posedge clk);
    endtask
    task automatic test_done();
        if (n_fail == 0 && n_compared > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    initial begin
        repeat (100000) @(posedge clk);
        n_fail++;
        test_done();
    end

    initial begin
        int seen, bad, t2;
        logic [31:0] m, ma;
        logic e, ph;
        {rstn, por_node, psel, penable, pwrite, dir_rev, cur_limit, ref_osc_in} = 8'h00;
        {stop_req, restraint_en} = 2'h3;
        paddr = 8'h00;
        pwdata = 32'h0;
        repeat (16) @(posedge clk);
        rstn <= 1'b1;
        por_node <= 1'b1;
        tick(4);
        chk(32'(drive), 32'h0);
        chk(32'(power_save), 32'h1);
        chk(32'(speed_lock_flag_n), 32'h1);
        wr(bsc_pkg::ADDR_STATUS, 32'hFFFFFFFF);
        rd(bsc_pkg::ADDR_STATUS, m);
        chk(32'({m[9], m[5:3]}), 32'h9);
        apb(1'b0, 8'h14, 32'h0, m, e);
        chk(m, 32'h0);
        chk(32'(e), 32'h1);
        rd(bsc_pkg::ADDR_CTRL, m);
        chk(m, 32'h000000C0);
        wr(bsc_pkg::ADDR_CTRL, 32'h12345680);
        rd(bsc_pkg::ADDR_CTRL, m);
        chk(m, 32'h00000080);
        rd(bsc_pkg::ADDR_INT_MASK, m);
        chk(m, 32'h0);
        // trip twice: cleared once by stop, once by the reset node
        for (int k = 0; k < 2; k++) begin
            stop_req <= 1'b0;
            tick(1900);
            rd(bsc_pkg::ADDR_STATUS, m);
            chk(32'(m[5:3]), 32'h2);
            tick(200);
            rd(bsc_pkg::ADDR_STATUS, m);
            chk(32'(m[5:3]), 32'h4);
            chk(32'(drive), 32'h8);
            tick(500);
            rd(bsc_pkg::ADDR_STATUS, m);
            chk(32'(m[5:3]), 32'h4);
            if (k == 0) stop_req <= 1'b1;
            else por_node <= 1'b0;
            tick(4);
            chk(32'(drive), 32'h0);
            stop_req <= 1'b1;
            por_node <= 1'b1;
            tick(2);
            rd(bsc_pkg::ADDR_STATUS, m);
            chk(32'(m[5:3]), 32'h1);
        end
        rd(bsc_pkg::ADDR_INT_STAT, m);
        chk(32'(m[bsc_pkg::EV_TRIP]), 32'h1);
        chk(32'(irq), 32'h0);
        wr(bsc_pkg::ADDR_INT_MASK, 32'h4);
        chk(32'(irq), 32'h1);
        wr(bsc_pkg::ADDR_INT_STAT, 32'h4);
        chk(32'(irq), 32'h0);
        restraint_en <= 1'b0;
        stop_req <= 1'b0;
        for (int d = 0; d < 2; d++) begin
            dir_rev <= d[0];
            for (int s = 0; s < 6; s++) begin
                i_bsc_motor_model.set_hall(CODES[s]);
                tick(4);
                chk(32'(drive.hi), 32'(d ? LOWER[s] : UPPER[s]));
                chk(32'(drive.lo & ~(d ? UPPER[s] : LOWER[s])), 32'h0);
            end
        end
        rd(bsc_pkg::ADDR_STATUS, m);
        chk(32'(m[8:6]), 32'h5);
        i_bsc_motor_model.set_hall(3'h7);
        tick(4);
        chk(32'(drive), 32'h0);
        dir_rev <= 1'b0;
        i_bsc_motor_model.set_hall(3'h1);
        wr(bsc_pkg::ADDR_INT_STAT, 32'hF);
        wr(bsc_pkg::ADDR_INT_MASK, 32'h1);
        fire_at(cyc + 2);
        t2 = cyc + 33168;
        fire_at(t2);
        tick(4);
        chk(32'(disc_out), 32'h1);
        chk(32'(speed_lock_flag_n), 32'h0);
        chk(32'(irq), 32'h1);
        rd(bsc_pkg::ADDR_MEAS, ma);
        chk_rng(ma, 32'd16580, 32'd16750);
        rd(bsc_pkg::ADDR_CTRL, m);
        chk(32'(m[15:8]), 32'h1);
        watch(t2 + 11000 - cyc, seen, bad);
        chk(32'(seen != 0), 32'h1);
        chk(32'(bad), 32'h0);
        fire_at(t2 + 12000);
        rd(bsc_pkg::ADDR_MEAS, m);
        chk(m, ma);
        cur_limit <= 1'b1;
        tick(3);
        watch(10400, seen, bad);
        chk(32'(seen), 32'h0);
        chk(32'(bad), 32'h0);
        fire_at(t2 + 24000);
        cur_limit <= 1'b0;
        ph = phase_error_out;
        chk(32'(disc_out), 32'h0);
        chk(32'(speed_lock_flag_n), 32'h1);
        rd(bsc_pkg::ADDR_MEAS, m);
        chk_rng(m, 32'd11990, 32'd12010);
        rd(bsc_pkg::ADDR_INT_STAT, m);
        chk(m & 32'hA, 32'hA);
        rd(bsc_pkg::ADDR_CTRL, m);
        chk(32'(m[15:8]), 32'h0);
        fire_at(t2 + 24000 + 16384);
        chk(32'(phase_error_out), 32'(ph));
        test_done();
    end
endmodule // tb_top
